/* include/tos_pkg.sv */
// Purpose: Constants and types for the terminal-order phase-step sequencer
// Assumes: One clock domain, pclk at 10 MHz
// Notes:   Register offsets are byte addresses on a 32-bit APB bus
//
// Summary of operation
// RULE_01 - Final fetch: odd word to C, D
// RULE_02 - Prep step: set flag A, clear B
// RULE_03 - Phase one: final data high, service low
// RULE_04 - Phase one sets strobe-wait clock hold
// RULE_05 - Strobe with hold and no ack restarts
// RULE_06 - Terminal step sets both order flags
// RULE_07 - Build terminal byte from count, chain, halt
// RULE_08 - Terminal register drives data lines always
// RULE_09 - Controller uses bits 0, 3 only
// RULE_10 - Final step raises ack and ack hold
// RULE_11 - Ack held until strobe drops
// RULE_12 - Clock stopped until ack clears
// RULE_13 - Controller disconnects on strobe fall
// RULE_14 - Data chaining entered from phase one; the code starts it from idle on the chain pulse
// RULE_15 - Chain fetch parity error sets error flag
// RULE_16 - Chaining also makes bit 1 meaningful
// RULE_17 - Data-out first step loads C
// RULE_18 - Low address bits into byte level
// RULE_19 - Second step moves C into A
// RULE_20 - Second step decrements byte level
// RULE_21 - Zero level exits, else keep shifting
// RULE_22 - State advances only with clock enable
package tos_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [7:0] TOS_CTRL_OFS   = 8'h00; // Start and conditions
   localparam logic [7:0] TOS_CWORD_OFS  = 8'h04; // Odd command word in
   localparam logic [7:0] TOS_DWORD_OFS  = 8'h08; // Data word in
   localparam logic [7:0] TOS_STAT_OFS   = 8'h0C; // State and flags
   localparam logic [7:0] TOS_CREG_OFS   = 8'h10; // C register
   localparam logic [7:0] TOS_DREG_OFS   = 8'h14; // D register
   localparam logic [7:0] TOS_AREG_OFS   = 8'h18; // A register

   // ==========================================================
   // Control register fields
   // ==========================================================
   localparam int TOS_CTL_GO_ORDER  = 0;  // Pulse: run order-out close
   localparam int TOS_CTL_GO_CHAIN  = 1;  // Pulse: run data chaining
   localparam int TOS_CTL_GO_DOUT   = 2;  // Pulse: run data-out start
   localparam int TOS_CTL_VALID_ORDER_COND    = 3;  // Valid order condition
   localparam int TOS_CTL_ZCOUNT    = 4;  // Zero byte count flag
   localparam int TOS_CTL_ZIRQ      = 5;  // Zero count irq enable
   localparam int TOS_CTL_NODCH     = 6;  // No data chain condition
   localparam int TOS_CTL_CMDCH     = 7;  // Command chain flag
   localparam int TOS_CTL_HALT      = 8;  // Channel halt flag
   localparam int TOS_CTL_PARERR    = 9;  // Memory parity error
   localparam int TOS_CTL_DATAIN    = 10; // Chain from data-in
   localparam int TOS_CTL_ADDR_LO   = 11; // Two low byte-address bits
   localparam int TOS_CTL_W         = 13; // Stored control width

   // ==========================================================
   // Terminal order byte bits
   // ==========================================================
   localparam int TOS_TO_ZIRQ  = 0;
   localparam int TOS_TO_ZCNT  = 1;
   localparam int TOS_TO_CMDCH = 2;
   localparam int TOS_TO_HALT  = 3;

   // ==========================================================
   // Phase steps
   // ==========================================================
   typedef enum logic [3:0] {
      TOS_IDLE,      // Waiting for a start
      TOS_FETCH,     // Final fetch, odd word to C and D
      TOS_PREP,      // Phase zero preparation
      TOS_REQ,       // Phase one, request terminal order
      TOS_TERM,      // Terminal order step, strobe gated
      TOS_FINAL,     // Final byte exchange
      TOS_ACKWAIT,   // Clock stopped for ack release
      TOS_DLOAD,     // Data-out, word into C
      TOS_DMOVE,     // Data-out, C into A
      TOS_DSHIFT,    // Data-out, shift until level zero
      TOS_DBYTE      // Phase zero byte transfer exit
   } tos_state_t;

   typedef enum logic [1:0] {
      TOS_SEQ_ORDER,
      TOS_SEQ_CHAIN_OUT,
      TOS_SEQ_CHAIN_IN
   } tos_seq_t;

   localparam logic [31:0] TOS_RDATA_RST = 32'h0000_0000;

endpackage

/* hw/tos_sync2.sv */
// Purpose: Two flip-flop synchroniser for one pin input
// Assumes: Input is asynchronous to pclk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module tos_sync2 (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q; // First stage

   // ==========================================================
   // Synchroniser chain
   // ==========================================================
   // Two stages with constant reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // tos_sync2

/* hw/tos_byte_level.sv */
// Purpose: Two-bit byte-level counter for data-out shifting
// Assumes: Load and decrement never asserted together
// Notes:   Higher address bit goes to counter bit 0
`timescale 1ns/1ns
module tos_byte_level (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       load,
   input  wire logic [1:0] addr_lo,
   input  wire logic       dec,
   output logic [1:0]      level_q,
   output logic            level_zero
);
   logic [1:0] level_d; // Next count

   // ==========================================================
   // Counter next value
   // ==========================================================
   always_comb begin
      level_d = level_q;
      if (load) begin
         // RULE_18 swapped bit load
         level_d = {addr_lo[0], addr_lo[1]};
      end else if (dec) begin
         // RULE_20 decrement by one
         level_d = level_q - 2'h1;
      end
   end

   // Counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 2'h0;
      end else begin
         level_q <= level_d;
      end
   end

   // RULE_21 zero on both clear
   assign level_zero = (level_q == 2'h0);
endmodule // tos_byte_level

/* hw/tos_seq.sv */
// Purpose: Terminal-order phase-step sequencer with APB registers
// Assumes: pclk 10 MHz, controller strobe arrives asynchronously
// Notes:   Clock enable gate holds all step state except the ack while waiting
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module tos_seq (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        controller_request_strobe,
   output logic             final_data_qualifier,
   output logic             final_service_qualifier,
   output logic             strobe_ack,
   output logic [7:0]       interface_data_lines
);

   // ==========================================================
   // Declarations
   // ==========================================================
   tos_pkg::tos_state_t state_q, state_d;     // Phase step
   tos_pkg::tos_seq_t   seq_q, seq_d;         // Running sequence
   logic [tos_pkg::TOS_CTL_W-1:0] ctl_q, ctl_d; // Stored conditions
   logic [31:0] cword_q, cword_d;             // Odd command word in
   logic [31:0] dword_q, dword_d;             // Data word in
   logic [31:0] c_reg_q, c_reg_d;             // C register
   logic [31:0] d_reg_q, d_reg_d;             // D register
   logic [31:0] a_reg_q, a_reg_d;             // A register
   logic        sum_a_q, sum_a_d;             // Adder preset A to sum
   logic        sum_c_q, sum_c_d;             // Adder preset C to sum
   logic        order_flag_a, order_flag_a_d;
   logic        order_flag_b, order_flag_b_d;
   logic        terminal_pending_flag, tp_d;
   logic        transmission_error_flag, te_d;
   logic        strobe_wait_clock_hold, swh_d;
   logic        ack_wait_clock_hold, awh_d;
   logic        ack_d;                        // Next ack
   logic [7:0]  terminal_order_register, tor_d;
   logic        clock_enable_gate;            // Step may advance
   logic        rs_sync;                      // Synchronised strobe
   logic        bl_load, bl_dec, byte_level_zero;
   logic [1:0]  byte_level;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;
   logic        wr_en, rd_en, addr_ok;
   logic [2:0]  go;                           // Start pulses

   // ==========================================================
   // Pin input synchroniser and byte-level counter
   // ==========================================================
   tos_sync2 u_rs_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (controller_request_strobe),
      .sync_out (rs_sync)
   );

   tos_byte_level u_level (
      .pclk       (pclk),
      .presetn    (presetn),
      .load       (bl_load),
      .addr_lo    (ctl_q[tos_pkg::TOS_CTL_ADDR_LO +: 2]),
      .dec        (bl_dec),
      .level_q    (byte_level),
      .level_zero (byte_level_zero)
   );

   // ==========================================================
   // APB decode
   // ==========================================================
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && !penable && !pwrite;
   assign addr_ok = (paddr == tos_pkg::TOS_CTRL_OFS)
                 || (paddr == tos_pkg::TOS_CWORD_OFS)
                 || (paddr == tos_pkg::TOS_DWORD_OFS)
                 || (paddr == tos_pkg::TOS_STAT_OFS)
                 || (paddr == tos_pkg::TOS_CREG_OFS)
                 || (paddr == tos_pkg::TOS_DREG_OFS)
                 || (paddr == tos_pkg::TOS_AREG_OFS);

   // Bus answer: ready one cycle into access, error on bad address
   always_comb begin
      pready_d  = psel && !penable;
      pslverr_d = psel && !penable && !addr_ok;
      prdata_d  = prdata;
      go        = 3'h0;
      ctl_d     = ctl_q;
      cword_d   = cword_q;
      dword_d   = dword_q;
      if (rd_en) begin
         case (paddr)
            tos_pkg::TOS_CTRL_OFS:  prdata_d = {19'h0, ctl_q};
            tos_pkg::TOS_CWORD_OFS: prdata_d = cword_q;
            tos_pkg::TOS_DWORD_OFS: prdata_d = dword_q;
            tos_pkg::TOS_STAT_OFS:  prdata_d = {12'h0, byte_level,
               2'(seq_q), 4'(state_q), terminal_order_register,
               transmission_error_flag, terminal_pending_flag,
               order_flag_b, order_flag_a};
            tos_pkg::TOS_CREG_OFS:  prdata_d = c_reg_q;
            tos_pkg::TOS_DREG_OFS:  prdata_d = d_reg_q;
            tos_pkg::TOS_AREG_OFS:  prdata_d = a_reg_q;
            default:                prdata_d = tos_pkg::TOS_RDATA_RST;
         endcase
      end
      if (wr_en && !pslverr) begin
         case (paddr)
            tos_pkg::TOS_CTRL_OFS: begin
               ctl_d = pwdata[tos_pkg::TOS_CTL_W-1:0];
               go    = pwdata[2:0];
            end
            tos_pkg::TOS_CWORD_OFS: cword_d = pwdata;
            tos_pkg::TOS_DWORD_OFS: dword_d = pwdata;
            default: ;
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= tos_pkg::TOS_RDATA_RST;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         ctl_q   <= '0;
         cword_q <= 32'h0000_0000;
         dword_q <= 32'h0000_0000;
      end else begin
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
         ctl_q   <= ctl_d;
         cword_q <= cword_d;
         dword_q <= dword_d;
      end
   end

   // ==========================================================
   // Clock enable gate
   // ==========================================================
   // Gate from the two hold flip-flops and the handshake
   always_comb begin
      clock_enable_gate = 1'b1;
      if (strobe_wait_clock_hold) begin
         // RULE_05 strobe restarts clock
         clock_enable_gate = !strobe_ack && rs_sync;
      end else if (ack_wait_clock_hold) begin
         // RULE_12 wait ack clear
         clock_enable_gate = !strobe_ack;
      end
   end

   // ==========================================================
   // Phase-step next state
   // ==========================================================
   always_comb begin
      state_d        = state_q;
      seq_d          = seq_q;
      c_reg_d        = c_reg_q;
      d_reg_d        = d_reg_q;
      a_reg_d        = a_reg_q;
      sum_a_d        = sum_a_q;
      sum_c_d        = sum_c_q;
      order_flag_a_d = order_flag_a;
      order_flag_b_d = order_flag_b;
      tp_d           = terminal_pending_flag;
      te_d           = transmission_error_flag;
      swh_d          = strobe_wait_clock_hold;
      awh_d          = ack_wait_clock_hold;
      ack_d          = strobe_ack;
      tor_d          = terminal_order_register;
      bl_load        = 1'b0;
      bl_dec         = 1'b0;
      // RULE_11 ack drops with strobe
      if (strobe_ack && !rs_sync) begin
         ack_d = 1'b0;
      end
      // RULE_22 advance only when enabled
      if (clock_enable_gate) begin
         case (state_q)
            tos_pkg::TOS_IDLE: begin
               // RULE_14 chaining entry points
               if (go[tos_pkg::TOS_CTL_GO_ORDER]) begin
                  seq_d   = tos_pkg::TOS_SEQ_ORDER;
                  state_d = tos_pkg::TOS_FETCH;
               end else if (go[tos_pkg::TOS_CTL_GO_CHAIN]) begin
                  seq_d = ctl_d[tos_pkg::TOS_CTL_DATAIN]
                        ? tos_pkg::TOS_SEQ_CHAIN_IN
                        : tos_pkg::TOS_SEQ_CHAIN_OUT;
                  state_d = tos_pkg::TOS_FETCH;
               end else if (go[tos_pkg::TOS_CTL_GO_DOUT]) begin
                  state_d = tos_pkg::TOS_DLOAD;
               end
               tp_d = go[tos_pkg::TOS_CTL_GO_ORDER]
                   || go[tos_pkg::TOS_CTL_GO_CHAIN];
            end
            tos_pkg::TOS_FETCH: begin
               // RULE_01 odd word to C and D
               c_reg_d = cword_q;
               d_reg_d = cword_q;
               // RULE_15 parity error in chain
               if (seq_q != tos_pkg::TOS_SEQ_ORDER
                   && ctl_q[tos_pkg::TOS_CTL_PARERR]) begin
                  te_d = 1'b1;
               end
               state_d = tos_pkg::TOS_PREP;
            end
            tos_pkg::TOS_PREP: begin
               // RULE_02 flag A set, B clear
               order_flag_a_d = 1'b1;
               order_flag_b_d = 1'b0;
               if (ctl_q[tos_pkg::TOS_CTL_VALID_ORDER_COND]) begin
                  sum_a_d = 1'b1;
               end
               state_d = tos_pkg::TOS_REQ;
            end
            tos_pkg::TOS_REQ: begin
               // RULE_04 hold clock for strobe
               swh_d   = 1'b1;
               state_d = tos_pkg::TOS_TERM;
            end
            tos_pkg::TOS_TERM: begin
               swh_d = 1'b0;
               // RULE_06 both order flags set
               order_flag_a_d = 1'b1;
               order_flag_b_d = 1'b1;
               // RULE_07 assemble terminal byte
               tor_d = 8'h00;
               tor_d[tos_pkg::TOS_TO_ZIRQ] =
                  ctl_q[tos_pkg::TOS_CTL_ZCOUNT]
                  && ctl_q[tos_pkg::TOS_CTL_ZIRQ];
               // RULE_16 count bit for chaining
               tor_d[tos_pkg::TOS_TO_ZCNT] =
                  ctl_q[tos_pkg::TOS_CTL_ZCOUNT]
                  && ctl_q[tos_pkg::TOS_CTL_NODCH];
               tor_d[tos_pkg::TOS_TO_CMDCH] =
                  ctl_q[tos_pkg::TOS_CTL_CMDCH];
               tor_d[tos_pkg::TOS_TO_HALT] = ctl_q[tos_pkg::TOS_CTL_HALT];
               state_d = tos_pkg::TOS_FINAL;
            end
            tos_pkg::TOS_FINAL: begin
               // RULE_10 raise ack and ack hold
               if (terminal_pending_flag) begin
                  ack_d = 1'b1;
                  awh_d = 1'b1;
               end
               state_d = tos_pkg::TOS_ACKWAIT;
            end
            tos_pkg::TOS_ACKWAIT: begin
               awh_d   = 1'b0;
               tp_d    = 1'b0;
               sum_a_d = 1'b0;
               state_d = tos_pkg::TOS_IDLE;
            end
            tos_pkg::TOS_DLOAD: begin
               // RULE_17 data word to C
               c_reg_d = dword_q;
               sum_c_d = 1'b1;
               // RULE_18 load byte level
               bl_load = 1'b1;
               state_d = tos_pkg::TOS_DMOVE;
            end
            tos_pkg::TOS_DMOVE: begin
               // RULE_19 C through sum to A
               a_reg_d = c_reg_q;
               sum_c_d = 1'b0;
               // RULE_20 count down
               bl_dec  = 1'b1;
               state_d = (byte_level == 2'h1) ? tos_pkg::TOS_DBYTE
                                              : tos_pkg::TOS_DSHIFT;
            end
            tos_pkg::TOS_DSHIFT: begin
               // RULE_21 shift until zero
               if (byte_level_zero) begin
                  state_d = tos_pkg::TOS_DBYTE;
               end else begin
                  a_reg_d = {a_reg_q[23:0], 8'h00};
                  bl_dec  = 1'b1;
               end
            end
            tos_pkg::TOS_DBYTE: begin
               state_d = tos_pkg::TOS_IDLE;
            end
            default: state_d = tos_pkg::TOS_IDLE;
         endcase
      end
   end

   // Step state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q                 <= tos_pkg::TOS_IDLE;
         seq_q                   <= tos_pkg::TOS_SEQ_ORDER;
         c_reg_q                 <= 32'h0000_0000;
         d_reg_q                 <= 32'h0000_0000;
         a_reg_q                 <= 32'h0000_0000;
         sum_a_q                 <= 1'b0;
         sum_c_q                 <= 1'b0;
         order_flag_a            <= 1'b0;
         order_flag_b            <= 1'b0;
         terminal_pending_flag   <= 1'b0;
         transmission_error_flag <= 1'b0;
         strobe_wait_clock_hold  <= 1'b0;
         ack_wait_clock_hold     <= 1'b0;
         strobe_ack              <= 1'b0;
         terminal_order_register <= 8'h00;
      end else begin
         state_q                 <= state_d;
         seq_q                   <= seq_d;
         c_reg_q                 <= c_reg_d;
         d_reg_q                 <= d_reg_d;
         a_reg_q                 <= a_reg_d;
         sum_a_q                 <= sum_a_d;
         sum_c_q                 <= sum_c_d;
         order_flag_a            <= order_flag_a_d;
         order_flag_b            <= order_flag_b_d;
         terminal_pending_flag   <= tp_d;
         transmission_error_flag <= te_d;
         strobe_wait_clock_hold  <= swh_d;
         ack_wait_clock_hold     <= awh_d;
         strobe_ack              <= ack_d;
         terminal_order_register <= tor_d;
      end
   end

   // ==========================================================
   // Pin outputs
   // ==========================================================
   // RULE_03 qualifiers follow order flags
   assign final_data_qualifier    = order_flag_a;
   assign final_service_qualifier = order_flag_b;
   // RULE_08 terminal byte on data lines
   assign interface_data_lines    = terminal_order_register;

endmodule // tos_seq

/* test/tos_seq_assertions.sv */
// Purpose: Port-level checks for the terminal-order sequencer
// Assumes: One pclk domain, presetn asynchronous and active low
// Notes:   Bound to tos_seq from the bench top file
`timescale 1ns/1ns
module tos_seq_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        controller_request_strobe,
   input wire logic        final_data_qualifier,
   input wire logic        final_service_qualifier,
   input wire logic        strobe_ack,
   input wire logic [7:0]  interface_data_lines
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Register bus and handshake
   a_apb_one_wait: assert property // Access answered next cycle
      (psel && !penable |=> pready) else $error("no ready after setup");
   a_ack_both_q: assert property
      (strobe_ack |-> final_data_qualifier && final_service_qualifier)
      else $error("ack without both qualifiers");
   a_ack_on_strobe: assert property
      ($rose(strobe_ack) |-> controller_request_strobe)
      else $error("ack rose without strobe");
   a_ack_holds: assert property
      (strobe_ack && controller_request_strobe |=> strobe_ack)
      else $error("ack dropped while strobe high");
   a_ack_drops: assert property
      ($fell(controller_request_strobe) |-> ##[1:4] !strobe_ack)
      else $error("ack stuck after strobe fell");
   a_ack_frozen: assert property
      (strobe_ack ##1 strobe_ack |-> $stable({final_data_qualifier,
         final_service_qualifier, interface_data_lines}))
      else $error("state moved while clock held");
   a_b_after_strobe: assert property
      ($rose(final_service_qualifier) |-> final_data_qualifier &&
         controller_request_strobe) else $error("flag B rose early");
   a_hi_bits_zero: assert property
      (interface_data_lines[7:4] == 4'h0) else $error("upper order bits");
   a_req_quals: assert property
      ($rose(final_data_qualifier) |-> !final_service_qualifier)
      else $error("request qualifiers wrong");
endmodule // tos_seq_chk

/* test/tos_ctrl_model.sv */
// Purpose: Behavioural device controller on the strobe handshake
// Assumes: Bench calls exchange just after a rising edge
// Notes:   Strobe idles low, driven by the controller at all times
`timescale 1ns/1ns
module tos_ctrl_model (
   input  wire logic       pclk,
   input  wire logic       strobe_ack,
   input  wire logic       final_data_qualifier,
   input  wire logic       final_service_qualifier,
   input  wire logic [7:0] interface_data_lines,
   output logic            controller_request_strobe
);
   initial controller_request_strobe = 1'b0;
   // One terminal-order exchange, dly cycles before each edge
   task automatic exchange(input int dly, input logic chain,
                           output logic [7:0] got, output logic ok);
      int n;
      ok = 1'b0;
      repeat (dly) @(posedge pclk);
      controller_request_strobe <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (strobe_ack !== 1'b1 && n < 40);
      ok = (strobe_ack === 1'b1);
      got = interface_data_lines & (chain ? 8'h0B : 8'h09);
      repeat (dly) @(posedge pclk);
      controller_request_strobe <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (strobe_ack !== 1'b0 && n < 40);
      ok = ok && (n < 40) && final_data_qualifier && final_service_qualifier;
   endtask
endmodule // tos_ctrl_model

/* test/tb.sv */
// Purpose: Self-checking bench for the terminal-order sequencer
// Assumes: APB slave answers with one access cycle
// Notes:   Data-out runs last; it returns to idle through TOS_DBYTE
`timescale 1ns/1ns
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
   logic [7:0]  paddr, idl, got;
   logic [31:0] pwdata, prdata, rd;
   logic        crs, fdq, fsq, sack, err, ok;
   logic [12:0] tab [5] = '{13'h0038, 13'h0058, 13'h0088, 13'h0108,
                            13'h01F8};
   int          miscompares = 0;
   int          n_tests = 0;
   tos_seq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .controller_request_strobe(crs), .final_data_qualifier(fdq),
      .final_service_qualifier(fsq), .strobe_ack(sack),
      .interface_data_lines(idl));
   tos_ctrl_model i_ctrl (.pclk(pclk), .strobe_ack(sack),
      .final_data_qualifier(fdq), .final_service_qualifier(fsq),
      .interface_data_lines(idl), .controller_request_strobe(crs));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer, then one idle cycle
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         tally_and_finish;
      end
      @(posedge pclk);
   endtask
   function automatic logic [7:0] exp_to(input logic [12:0] c);
      exp_to = {4'h0, c[8], c[7], c[4] & c[6], c[4] & c[5]};
   endfunction
   task automatic wait_idle;
      int n;
      for (n = 0; n < 20; n++) begin
         apb(1'b0, tos_pkg::TOS_STAT_OFS, 32'h0);
         if (rd[15:12] === 4'h0) break;
      end
      chk("idle", {28'h0, rd[15:12]}, 32'h0);
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, tos_pkg::TOS_STAT_OFS, 32'h0);
      chk("stat_rst", rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", {31'h0, err}, 32'h1);
      chk("unmapped_rd", rd, 32'h0);
      foreach (tab[i]) begin
         apb(1'b1, tos_pkg::TOS_CWORD_OFS, 32'hA5C3_0000 + i);
         apb(1'b1, tos_pkg::TOS_CTRL_OFS, {19'h0, tab[i] | 13'h1});
         repeat (4) @(posedge pclk);
         chk("qual_a", {31'h0, fdq}, 32'h1);
         chk("qual_b", {31'h0, fsq}, 32'h0);
         i_ctrl.exchange(i, 1'b0, got, ok);
         chk("xchg", {31'h0, ok}, 32'h1);
         chk("to_byte", {24'h0, got},
             {24'h0, exp_to(tab[i]) & 8'h09});
         wait_idle;
         chk("pins", {24'h0, idl}, {24'h0, exp_to(tab[i])});
         apb(1'b0, tos_pkg::TOS_DREG_OFS, 32'h0);
         chk("dreg", rd, 32'hA5C3_0000 + i);
      end
      apb(1'b1, tos_pkg::TOS_CTRL_OFS, 32'h0000_065A);
      repeat (4) @(posedge pclk);
      apb(1'b0, tos_pkg::TOS_STAT_OFS, 32'h0);
      chk("seq", {30'h0, rd[17:16]}, 32'h2);
      chk("txerr", {31'h0, rd[3]}, 32'h1);
      i_ctrl.exchange(1, 1'b1, got, ok);
      chk("chain_byte", {24'h0, got}, 32'h02);
      wait_idle;
      apb(1'b1, tos_pkg::TOS_DWORD_OFS, 32'h1122_3344);
      apb(1'b1, tos_pkg::TOS_CTRL_OFS, 32'h0000_0804);
      repeat (10) @(posedge pclk);
      apb(1'b0, tos_pkg::TOS_CREG_OFS, 32'h0);
      chk("creg", rd, 32'h1122_3344);
      apb(1'b0, tos_pkg::TOS_AREG_OFS, 32'h0);
      chk("areg", rd, 32'h2233_4400);
      apb(1'b0, tos_pkg::TOS_STAT_OFS, 32'h0);
      chk("level", {30'h0, rd[19:18]}, 32'h0);
      tally_and_finish;
   end
endmodule // tb
bind tos_seq tos_seq_chk i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .controller_request_strobe(controller_request_strobe),
   .final_data_qualifier(final_data_qualifier),
   .final_service_qualifier(final_service_qualifier),
   .strobe_ack(strobe_ack), .interface_data_lines(interface_data_lines));
